// file: logic/ilc_consts.vh
// Constants for the interrupt level control block: offsets, fields, resets and vectors.
`ifndef ILC_CONSTS_VH
`define ILC_CONSTS_VH

// ****************************************************************************
// Register locations in register set 1
// ****************************************************************************
`define ILC_ADDR_LEVEL_REQUEST   8'hdc
`define ILC_ADDR_LEVEL_MASK      8'hdd
`define ILC_ADDR_SYSTEM_MODE     8'hde
`define ILC_ADDR_LEVEL_PRIORITY  8'hff
`define ILC_BANK_LEVEL_PRIORITY  1'b0

// ****************************************************************************
// System mode fields
// ****************************************************************************
`define ILC_SYM_GIE_BIT          0
`define ILC_SYM_FIE_BIT          1
`define ILC_SYM_FLS_LSB          2
`define ILC_SYM_FLS_MSB          4
`define ILC_SYM_GIE_RESET        1'b0
`define ILC_SYM_FIE_RESET        1'b0
`define ILC_LEVEL_REQUEST_RESET  8'h00
`define ILC_RDATA_RESET          8'h00

// ****************************************************************************
// Level priority fields
// ****************************************************************************
`define ILC_PRI_PAIR_A_BIT       0
`define ILC_PRI_GRP_LO_BIT       1
`define ILC_PRI_B_FIRST_BIT      2
`define ILC_PRI_B_PAIR_BIT       3
`define ILC_PRI_GRP_MID_BIT      4
`define ILC_PRI_C_FIRST_BIT      5
`define ILC_PRI_C_PAIR_BIT       6
`define ILC_PRI_GRP_HI_BIT       7

// Group order codes on bits 7,4,1.
`define ILC_GO_B_C_A             3'b001
`define ILC_GO_A_B_C             3'b010
`define ILC_GO_B_A_C             3'b011
`define ILC_GO_C_A_B             3'b100
`define ILC_GO_C_B_A             3'b101
`define ILC_GO_A_C_B             3'b110

// ****************************************************************************
// Vector addresses, one per source, in source index order
// ****************************************************************************
`define ILC_VEC_S0               8'hf0
`define ILC_VEC_S1               8'hf2
`define ILC_VEC_S2               8'hf4
`define ILC_VEC_S3               8'hf6
`define ILC_VEC_S4               8'he0
`define ILC_VEC_S5               8'he2
`define ILC_VEC_S6               8'he4
`define ILC_VEC_S7               8'he6
`define ILC_VEC_S8               8'he8
`define ILC_VEC_S9               8'hea
`define ILC_VEC_S10              8'hec
`define ILC_VEC_S11              8'hee

`endif

// file: logic/ilc_src_pick.v
// Fixed-order picker: lowest set index wins among the sources of one level.
module ilc_src_pick #(
   parameter N = 4
) (
   input  wire [N-1:0] act,     // Active sources, index 0 first
   output reg          valid,   // Any source active
   output reg  [1:0]   idx      // Index of the winning source
);

   integer i;

   // Scan from the top down so the lowest index is written last and wins.
   always @* begin
      valid = 1'b0;
      idx   = 2'd0;
      for (i = N - 1; i >= 0; i = i - 1) begin
         if (act[i]) begin
            valid = 1'b1;
            idx   = i[1:0];
         end
      end
   end

endmodule // ilc_src_pick

// file: logic/ilc_grp_pick.v
// Group picker: one leading level against a subgroup pair, each order set by a bit.
module ilc_grp_pick (
   input  wire [2:0] act,        // Active levels: [0] leader, [1] and [2] the pair
   input  wire       pair_first, // 1: the pair outranks the leader
   input  wire       pair_swap,  // 1: entry 2 outranks entry 1 inside the pair
   output reg        valid,      // Any level of the group active
   output reg  [1:0] sel         // Winning entry 0..2
);

   reg       pv;
   reg [1:0] ps;

   // Resolve the pair first, then weigh it against the leader.
   always @* begin
      pv = act[1] | act[2];
      if (pair_swap) begin
         ps = act[2] ? 2'd2 : 2'd1;
      end else begin
         ps = act[1] ? 2'd1 : 2'd2;
      end
      valid = pv | act[0];
      if (act[0] && (!pv || !pair_first)) begin
         sel = 2'd0;
      end else begin
         sel = ps;
      end
   end

endmodule // ilc_grp_pick

// file: logic/ilc_level_ctrl.v
// Interrupt level control: mask, priority, request and system mode registers.
`include "ilc_consts.vh"

module ilc_level_ctrl #(
   parameter NSRC = 12
) (
   input  wire            clk_sys,          // System clock, 20 MHz
   input  wire            reset,            // Synchronous reset, active high
   input  wire [7:0]      reg_addr,         // Register address within set 1
   input  wire            reg_bank,         // Bank select for banked locations
   input  wire            reg_wr,           // Register write strobe
   input  wire            reg_rd,           // Register read strobe
   input  wire [7:0]      reg_wdata,        // Register write data
   output reg  [7:0]      reg_rdata_q,      // Read data, one cycle after reg_rd
   output reg             reg_hit_q,        // Read hit a register of this block
   input  wire [NSRC-1:0] src_pend,         // Source pending flags, vector order
   input  wire [NSRC-1:0] src_en,           // Source enables from peripheral control
   input  wire            enable_interrupts_instr,  // Enable instruction executed
   input  wire            disable_interrupts_instr, // Disable instruction executed
   input  wire            interrupt_return_instr,   // Interrupt return executed
   input  wire            int_ack,          // CPU acknowledges the offered interrupt
   output reg             int_req_q,        // A serviceable interrupt is offered
   output reg  [2:0]      int_level_q,      // Level of the offered interrupt
   output reg  [3:0]      int_src_q,        // Source index of the offered interrupt
   output reg  [7:0]      int_vector_q,     // Vector address of the offered interrupt
   output reg             int_fast_q,       // Offered level uses fast processing
   output reg             global_int_enable_q // Global enable state
);

   // ************************************************************************
   // Register storage
   // ************************************************************************
   reg  [7:0] level_mask_q;       // No reset: contents undefined until written.
   reg  [7:0] level_priority_q;   // No reset: contents undefined until written.
   reg  [2:0] fast_level_select_q;
   reg        fast_int_enable_q;
   reg  [7:0] level_request_q;
   reg  [7:0] system_mode_rd;
   reg  [7:0] rdata_d;
   reg        hit_d;

   wire sel_mask = (reg_addr == `ILC_ADDR_LEVEL_MASK);
   wire sel_sym  = (reg_addr == `ILC_ADDR_SYSTEM_MODE);
   wire sel_req  = (reg_addr == `ILC_ADDR_LEVEL_REQUEST);
   wire sel_pri  = (reg_addr == `ILC_ADDR_LEVEL_PRIORITY) &&
                   (reg_bank == `ILC_BANK_LEVEL_PRIORITY);

   // Mask and priority registers carry no reset; software must load them.
   always @(posedge clk_sys) begin
      if (reg_wr && sel_mask) begin
         level_mask_q <= reg_wdata;
      end
      if (reg_wr && sel_pri) begin
         level_priority_q <= reg_wdata;
      end
      if (reg_wr && sel_sym) begin
         fast_level_select_q <= reg_wdata[`ILC_SYM_FLS_MSB:`ILC_SYM_FLS_LSB];
      end
   end

   // Fast enable: cleared by reset, otherwise a plain software bit.
   always @(posedge clk_sys) begin
      if (reset) begin
         fast_int_enable_q <= `ILC_SYM_FIE_RESET;
      end else if (reg_wr && sel_sym) begin
         fast_int_enable_q <= reg_wdata[`ILC_SYM_FIE_BIT];
      end
   end

   // Global enable. The hardware acknowledge outranks any software set in the
   // same cycle, so a grant can never leave the structure enabled by accident.
   always @(posedge clk_sys) begin
      if (reset) begin
         global_int_enable_q <= `ILC_SYM_GIE_RESET;
      end else if (int_ack && int_req_q) begin
         global_int_enable_q <= 1'b0;
      end else if (disable_interrupts_instr) begin
         global_int_enable_q <= 1'b0;
      end else if (enable_interrupts_instr || interrupt_return_instr) begin
         global_int_enable_q <= 1'b1;
      end else if (reg_wr && sel_sym) begin
         global_int_enable_q <= reg_wdata[`ILC_SYM_GIE_BIT];
      end
   end

   // ************************************************************************
   // Level requests
   // ************************************************************************
   // Source order: 0,1 -> level 0; 2..7 -> levels 1..6; 8..11 -> level 7.
   wire [NSRC-1:0] src_act = src_pend & src_en;
   wire [7:0] lvl_pend = {|src_pend[11:8], src_pend[7:2], |src_pend[1:0]};
   wire [7:0] lvl_srv  = {|src_act[11:8], src_act[7:2], |src_act[1:0]};
   wire [7:0] lvl_act  = lvl_srv & level_mask_q;

   // The request flags follow level requests, visible even while disabled.
   always @(posedge clk_sys) begin
      if (reset) begin
         level_request_q <= `ILC_LEVEL_REQUEST_RESET;
      end else begin
         level_request_q <= lvl_pend;
      end
   end

   // ************************************************************************
   // Register read path
   // ************************************************************************
   // Bits 7..5 of system mode are not held here and read as zero.
   always @* begin
      system_mode_rd = {3'b000, fast_level_select_q, fast_int_enable_q,
                        global_int_enable_q};
      rdata_d = 8'h00;
      hit_d   = 1'b1;
      if (sel_mask) begin
         rdata_d = level_mask_q;
      end else if (sel_sym) begin
         rdata_d = system_mode_rd;
      end else if (sel_req) begin
         rdata_d = level_request_q;
      end else if (sel_pri) begin
         rdata_d = level_priority_q;
      end else begin
         hit_d = 1'b0;
      end
   end

   // Read data is captured on the strobe and held until the next read.
   always @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata_q <= `ILC_RDATA_RESET;
         reg_hit_q   <= 1'b0;
      end else if (reg_rd) begin
         reg_rdata_q <= rdata_d;
         reg_hit_q   <= hit_d;
      end
   end

   // ************************************************************************
   // Group arbitration
   // ************************************************************************
   wire       ga_v;
   wire       gb_v;
   wire       gc_v;
   wire [1:0] ga_s;
   wire [1:0] gb_s;
   wire [1:0] gc_s;

   // Group A has no leader; only the pair order bit matters.
   ilc_grp_pick u_grp_a (
      .act        ({lvl_act[1], lvl_act[0], 1'b0}),
      .pair_first (1'b1),
      .pair_swap  (level_priority_q[`ILC_PRI_PAIR_A_BIT]),
      .valid      (ga_v),
      .sel        (ga_s)
   );

   ilc_grp_pick u_grp_b (
      .act        (lvl_act[4:2]),
      .pair_first (level_priority_q[`ILC_PRI_B_FIRST_BIT]),
      .pair_swap  (level_priority_q[`ILC_PRI_B_PAIR_BIT]),
      .valid      (gb_v),
      .sel        (gb_s)
   );

   ilc_grp_pick u_grp_c (
      .act        (lvl_act[7:5]),
      .pair_first (level_priority_q[`ILC_PRI_C_FIRST_BIT]),
      .pair_swap  (level_priority_q[`ILC_PRI_C_PAIR_BIT]),
      .valid      (gc_v),
      .sel        (gc_s)
   );

   wire [2:0] ga_lvl = {1'b0, ga_s} - 3'd1;
   wire [2:0] gb_lvl = {1'b0, gb_s} + 3'd2;
   wire [2:0] gc_lvl = {1'b0, gc_s} + 3'd5;
   wire [2:0] grp_code = {level_priority_q[`ILC_PRI_GRP_HI_BIT],
                          level_priority_q[`ILC_PRI_GRP_MID_BIT],
                          level_priority_q[`ILC_PRI_GRP_LO_BIT]};

   reg [1:0] rank0;   // Group ids: 0 = A, 1 = B, 2 = C.
   reg [1:0] rank1;
   reg [1:0] rank2;
   reg       win_v;
   reg [2:0] win_lvl;
   reg [2:0] gv;
   reg [8:0] glv;
   reg [1:0] pick;

   // Map the order code to a ranked list of groups. The two unused codes fall
   // back to A, B, C so an unprogrammed register still arbitrates cleanly.
   always @* begin
      case (grp_code)
         `ILC_GO_B_C_A: begin rank0 = 2'd1; rank1 = 2'd2; rank2 = 2'd0; end
         `ILC_GO_C_B_A: begin rank0 = 2'd2; rank1 = 2'd1; rank2 = 2'd0; end
         `ILC_GO_A_B_C: begin rank0 = 2'd0; rank1 = 2'd1; rank2 = 2'd2; end
         `ILC_GO_B_A_C: begin rank0 = 2'd1; rank1 = 2'd0; rank2 = 2'd2; end
         `ILC_GO_C_A_B: begin rank0 = 2'd2; rank1 = 2'd0; rank2 = 2'd1; end
         `ILC_GO_A_C_B: begin rank0 = 2'd0; rank1 = 2'd2; rank2 = 2'd1; end
         default:       begin rank0 = 2'd0; rank1 = 2'd1; rank2 = 2'd2; end
      endcase
   end

   // First valid group in rank order supplies the single winning level.
   always @* begin
      gv  = {gc_v, gb_v, ga_v};
      glv = {gc_lvl, gb_lvl, ga_lvl};
      if (gv[rank0]) begin
         pick = rank0;
      end else if (gv[rank1]) begin
         pick = rank1;
      end else begin
         pick = rank2;
      end
      win_v = |gv;
      case (pick)
         2'd0:    win_lvl = glv[2:0];
         2'd1:    win_lvl = glv[5:3];
         default: win_lvl = glv[8:6];
      endcase
   end

   // ************************************************************************
   // Source selection within the winning level
   // ************************************************************************
   wire [1:0] l0_idx;
   wire [1:0] l7_idx;

   ilc_src_pick #(.N(2)) u_src_l0 (
      .act   (src_act[1:0]),
      .valid (),
      .idx   (l0_idx)
   );

   ilc_src_pick #(.N(4)) u_src_l7 (
      .act   (src_act[11:8]),
      .valid (),
      .idx   (l7_idx)
   );

   reg [3:0] win_src;
   reg [7:0] win_vec;

   // Lower source index means lower vector address inside a shared level.
   always @* begin
      case (win_lvl)
         3'd0:    win_src = {3'b000, l0_idx[0]};
         3'd7:    win_src = {2'b10, l7_idx};
         default: win_src = {1'b0, win_lvl} + 4'd1;
      endcase
      case (win_src)
         4'd0:    win_vec = `ILC_VEC_S0;
         4'd1:    win_vec = `ILC_VEC_S1;
         4'd2:    win_vec = `ILC_VEC_S2;
         4'd3:    win_vec = `ILC_VEC_S3;
         4'd4:    win_vec = `ILC_VEC_S4;
         4'd5:    win_vec = `ILC_VEC_S5;
         4'd6:    win_vec = `ILC_VEC_S6;
         4'd7:    win_vec = `ILC_VEC_S7;
         4'd8:    win_vec = `ILC_VEC_S8;
         4'd9:    win_vec = `ILC_VEC_S9;
         4'd10:   win_vec = `ILC_VEC_S10;
         default: win_vec = `ILC_VEC_S11;
      endcase
   end

   // ************************************************************************
   // Offered interrupt
   // ************************************************************************
   // No offer is loaded while globally disabled, and the offer drops in the
   // cycle after an acknowledge because the acknowledge itself blocks the load at that edge.
   always @(posedge clk_sys) begin
      if (reset) begin
         int_req_q    <= 1'b0;
         int_level_q  <= 3'd0;
         int_src_q    <= 4'd0;
         int_vector_q <= 8'h00;
         int_fast_q   <= 1'b0;
      end else if (global_int_enable_q && !(int_ack && int_req_q) && win_v) begin
         int_req_q    <= 1'b1;
         int_level_q  <= win_lvl;
         int_src_q    <= win_src;
         int_vector_q <= win_vec;
         int_fast_q   <= fast_int_enable_q &&
                         (fast_level_select_q == win_lvl);
      end else begin
         int_req_q    <= 1'b0;
         int_level_q  <= 3'd0;
         int_src_q    <= 4'd0;
         int_vector_q <= 8'h00;
         int_fast_q   <= 1'b0;
      end
   end

endmodule // ilc_level_ctrl

// file: tb/ilc_props.sv
// Assertion checker for the interrupt level control block.
`include "ilc_consts.vh"
module ilc_props #(
   parameter NSRC = 12
) (
   input wire            clk_sys,                  // Clock
   input wire            reset,                    // Reset
   input wire [7:0]      reg_addr,                 // Address
   input wire            reg_rd,                   // Read
   input wire [7:0]      reg_rdata_q,              // Read data
   input wire            reg_hit_q,                // Read hit
   input wire [NSRC-1:0] src_pend,                 // Pending
   input wire [NSRC-1:0] src_en,                   // Enables
   input wire            enable_interrupts_instr,  // Enable
   input wire            disable_interrupts_instr, // Disable
   input wire            interrupt_return_instr,   // Return
   input wire            int_ack,                  // Acknowledge
   input wire            int_req_q,                // Offer
   input wire [2:0]      int_level_q,              // Level
   input wire [3:0]      int_src_q,                // Source
   input wire [7:0]      int_vector_q,             // Vector
   input wire            global_int_enable_q       // Enable state
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   // Sources are kept in vector order, so level and vector follow from the index.
   function automatic [2:0] lvl_of(input [3:0] s);
      lvl_of = (s < 2) ? 3'h0 : (s > 7) ? 3'h7 : 3'(s - 4'h1);
   endfunction
   function automatic [7:0] vec_of(input [3:0] s);
      vec_of = ((s < 4) ? 8'hf0 : 8'hd8) + {3'h0, s, 1'b0};
   endfunction
   function automatic [7:0] lvl_or(input [11:0] p);
      lvl_or = {|p[11:8], p[7:2], |p[1:0]};
   endfunction
   property p_req_gie;
      int_req_q |-> $past(global_int_enable_q);
   endproperty
   a_req_gie: assert property (p_req_gie) else $error("offer while disabled");
   property p_ack_clr;
      int_ack && int_req_q |=> !global_int_enable_q && !int_req_q;
   endproperty
   a_ack_clr: assert property (p_ack_clr) else $error("ack did not clear");
   property p_set;
      (enable_interrupts_instr || interrupt_return_instr) && !disable_interrupts_instr
         && !(int_ack && int_req_q) |=> global_int_enable_q;
   endproperty
   a_set: assert property (p_set) else $error("enable not set");
   property p_di;
      disable_interrupts_instr |=> !global_int_enable_q;
   endproperty
   a_di: assert property (p_di) else $error("disable not taken");
   property p_idle;
      !int_req_q |-> {int_level_q, int_src_q, int_vector_q} == 15'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("idle offer not zero");
   property p_src;
      int_req_q |-> int_level_q == lvl_of(int_src_q) && int_vector_q == vec_of(int_src_q);
   endproperty
   a_src: assert property (p_src) else $error("level or vector wrong");
   property p_hot;
      int_req_q |-> ((($past(src_pend) & $past(src_en)) >> int_src_q) & 12'h001) != 0;
   endproperty
   a_hot: assert property (p_hot) else $error("offer from idle source");
   property p_rd_sym;
      reg_rd && reg_addr == `ILC_ADDR_SYSTEM_MODE |=> reg_hit_q && reg_rdata_q[7:5] == 3'h0
         && reg_rdata_q[0] == $past(global_int_enable_q);
   endproperty
   a_rd_sym: assert property (p_rd_sym) else $error("mode read wrong");
   property p_rd_req;
      reg_rd && reg_addr == `ILC_ADDR_LEVEL_REQUEST && !$past(reset)
         |=> reg_rdata_q == lvl_or($past(src_pend, 2));
   endproperty
   a_rd_req: assert property (p_rd_req) else $error("request read wrong");
   c_ack: cover property (int_ack && int_req_q);
   c_lvl7: cover property (int_req_q && int_level_q == 3'h7);
   c_di: cover property (disable_interrupts_instr && int_req_q);
endmodule // ilc_props

bind ilc_level_ctrl ilc_props #(.NSRC(NSRC)) ilc_props_i (.clk_sys, .reset, .reg_addr,
   .reg_rd, .reg_rdata_q, .reg_hit_q, .src_pend, .src_en, .enable_interrupts_instr,
   .disable_interrupts_instr, .interrupt_return_instr, .int_ack, .int_req_q, .int_level_q,
   .int_src_q, .int_vector_q, .global_int_enable_q);

// file: tb/ilc_cpu_model.sv
// Partner model of the CPU core: acknowledges offers and returns from service.
module ilc_cpu_model (
   input  wire       clk_sys,                       // Clock
   input  wire       reset,                         // Reset
   input  wire       int_req_q,                     // Offer
   input  wire       ack_on,                        // Accept offers
   input  wire [1:0] ack_delay,                     // Wait before ack
   output logic      int_ack = 1'b0,                // Ack pulse
   output logic      interrupt_return_instr = 1'b0  // Return pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   bit busy = 1'b0;
   bit on = 1'b0;
   bit rst = 1'b1;
   // Acts just after each edge; the return comes four cycles after the ack.
   // The ack_on and reset controls are taken at the edge itself, because the bench moves
   // them at the same instant as this model acts and the order would be a race.
   always @(posedge clk_sys) begin
      on = ack_on;
      rst = reset;
      #1;
      int_ack = 1'b0;
      interrupt_return_instr = 1'b0;
      if (rst) begin
         cnt = 0;
         busy = 1'b0;
      end else if (busy) begin
         cnt++;
         if (cnt == 4) begin
            interrupt_return_instr = 1'b1;
            busy = 1'b0;
            cnt = 0;
         end
      end else if (on && int_req_q) begin
         if (cnt == ack_delay) begin
            int_ack = 1'b1;
            busy = 1'b1;
            cnt = 0;
         end else begin
            cnt++;
         end
      end else begin
         cnt = 0;
      end
   end
endmodule // ilc_cpu_model

// file: tb/tb_top.sv
// Self-checking testbench for the interrupt level control block.
`include "ilc_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys, reset, reg_bank, reg_wr, reg_rd, ack_on, int_ack, int_req_q;
   logic        enable_interrupts_instr, disable_interrupts_instr, interrupt_return_instr;
   logic        int_fast_q, global_int_enable_q, reg_hit_q;
   logic [1:0]  ack_delay;
   logic [2:0]  int_level_q;
   logic [3:0]  int_src_q;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, int_vector_q;
   logic [11:0] src_pend, src_en;
   int          n_mismatch = 0, num_checks = 0;
   logic [31:0] seed = 32'd77;
   int          lv[12] = '{0, 0, 1, 2, 3, 4, 5, 6, 7, 7, 7, 7};
   logic [7:0]  vec[12] = '{8'hf0, 8'hf2, 8'hf4, 8'hf6, 8'he0, 8'he2, 8'he4, 8'he6, 8'he8,
                           8'hea, 8'hec, 8'hee};
   ilc_level_ctrl ilc_level_ctrl_i (.clk_sys, .reset, .reg_addr, .reg_bank, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata_q, .reg_hit_q, .src_pend, .src_en, .enable_interrupts_instr,
      .disable_interrupts_instr, .interrupt_return_instr, .int_ack, .int_req_q, .int_level_q,
      .int_src_q, .int_vector_q, .int_fast_q, .global_int_enable_q);
   ilc_cpu_model ilc_cpu_model_i (.clk_sys, .reset, .int_req_q, .ack_on, .ack_delay,
      .int_ack, .interrupt_return_instr);
   // 20 MHz clock, and a watchdog well past the expected run length.
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      #400000;
      n_mismatch++;
      final_report();
   end
   function automatic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Level order from the priority byte; the first active level in it wins.
   function automatic [3:0] pick(input [7:0] pr, input [7:0] act);
      int q[$];
      int gs[3];
      int b;
      case ({pr[7], pr[4], pr[1]})
         3'b001: gs = '{1, 2, 0};
         3'b011: gs = '{1, 0, 2};
         3'b100: gs = '{2, 0, 1};
         3'b101: gs = '{2, 1, 0};
         3'b110: gs = '{0, 2, 1};
         default: gs = '{0, 1, 2};
      endcase
      foreach (gs[i]) begin
         b = (gs[i] == 1) ? 2 : 5;
         if (gs[i] == 0) q = {q, int'(pr[0]), int'(!pr[0])};
         else if (pr[b]) q = {q, b + 1 + pr[b + 1], b + 2 - pr[b + 1], b};
         else q = {q, b, b + 1 + pr[b + 1], b + 2 - pr[b + 1]};
      end
      foreach (q[i]) if (act[q[i]]) return {1'b1, 3'(q[i])};
      return 4'h0;
   endfunction
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick();
      s = 1'b0;
      tick();
   endtask
   task automatic wr(input [7:0] a, input [7:0] d);
      reg_addr = a;
      reg_bank = 1'b0;
      reg_wdata = d;
      pulse(reg_wr);
   endtask
   task automatic rd(input [7:0] a, input bk);
      reg_addr = a;
      reg_bank = bk;
      pulse(reg_rd);
   endtask
   task automatic final_report();
      if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Main sequence: reset values, refused accesses, then randomised arbitration rounds.
   initial begin
      logic [31:0] r;
      logic [16:0] exp;
      logic [11:0] hot;
      logic [7:0]  msk, pr, system_mode, act, exp_req;
      logic [3:0]  w;
      int          src;
      reset = 1'b1;
      {reg_bank, reg_wr, reg_rd, ack_on, reg_addr, reg_wdata, ack_delay} = '0;
      {enable_interrupts_instr, disable_interrupts_instr, src_pend, src_en} = '0;
      tick(12);
      reset = 1'b0;
      tick();
      `CHK({global_int_enable_q, int_req_q, int_level_q, int_src_q, int_vector_q}, 17'h0)
      rd(`ILC_ADDR_SYSTEM_MODE, 1'b0);
      `CHK(reg_rdata_q[1:0], 2'b00)
      wr(`ILC_ADDR_LEVEL_REQUEST, 8'hff);
      rd(`ILC_ADDR_LEVEL_REQUEST, 1'b0);
      `CHK({reg_hit_q, reg_rdata_q}, 9'h100)
      rd(`ILC_ADDR_LEVEL_PRIORITY, 1'b1);
      `CHK({reg_hit_q, reg_rdata_q}, 9'h000)
      for (int i = 0; i < 64; i++) begin
         pulse(disable_interrupts_instr);
         r = rnd();
         pr = {i[2], r[6:5], i[1], r[3:2], i[0], r[0]};
         system_mode = {3'b000, r[10:8], r[11], 1'b0};
         msk = r[23:16];
         wr(`ILC_ADDR_SYSTEM_MODE, system_mode);
         wr(`ILC_ADDR_LEVEL_MASK, msk);
         wr(`ILC_ADDR_LEVEL_PRIORITY, pr);
         r = rnd();
         src_pend = r[11:0];
         src_en = r[23:12];
         if (i[1]) pulse(enable_interrupts_instr);
         else wr(`ILC_ADDR_SYSTEM_MODE, system_mode | 8'h01);
         tick();
         hot = src_pend & src_en;
         {act, exp_req, src} = '0;
         for (int s = 11; s >= 0; s--) begin
            exp_req[lv[s]] |= src_pend[s];
            act[lv[s]] |= hot[s] & msk[lv[s]];
         end
         w = pick(pr, act);
         for (int s = 11; s >= 0; s--) if (hot[s] && lv[s] == w[2:0]) src = s;
         exp = w[3] ? {1'b1, w[2:0], 4'(src), vec[src], system_mode[1] && system_mode[4:2] == w[2:0]} : 17'h0;
         `CHK({int_req_q, int_level_q, int_src_q, int_vector_q, int_fast_q}, exp)
         rd(`ILC_ADDR_LEVEL_REQUEST, 1'b0);
         `CHK(reg_rdata_q, exp_req)
         rd(`ILC_ADDR_LEVEL_MASK, 1'b0);
         `CHK(reg_rdata_q, msk)
         rd(`ILC_ADDR_LEVEL_PRIORITY, 1'b0);
         `CHK(reg_rdata_q, pr)
         rd(`ILC_ADDR_SYSTEM_MODE, 1'b0);
         `CHK(reg_rdata_q, system_mode | 8'h01)
         if (i[0]) begin
            pulse(disable_interrupts_instr);
            `CHK({global_int_enable_q, int_req_q}, 2'b00)
         end else if (w[3]) begin
            ack_delay = i[3:2];
            ack_on = 1'b1;
            for (int k = 0; k < 8 && !int_ack; k++) @(posedge clk_sys);
            #1;
            ack_on = 1'b0;
            `CHK({global_int_enable_q, int_req_q}, 2'b00)
            tick(6);
            `CHK(global_int_enable_q, 1'b1)
         end
      end
      final_report();
   end
endmodule // tb_top
